/* pwmg_pkg.sv */
package pwmg_pkg;
    // Register indices: byte address = 4 * index
    localparam logic [7:0] IDX_DUTY_LOW    = 8'hb6;
    localparam logic [7:0] IDX_DUTY_HIGH   = 8'hb7;
    localparam logic [7:0] IDX_CONTROL     = 8'hdc;
    localparam logic [7:0] IDX_PERIOD_LOW  = 8'hdd;
    localparam logic [7:0] IDX_PERIOD_HIGH = 8'hde;
    localparam logic [7:0] IDX_IRQ_STATUS  = 8'he0;
    localparam logic [7:0] IDX_IRQ_CLEAR   = 8'he1;
    localparam logic [7:0] IDX_IRQ_ENABLE  = 8'he2;
    localparam logic [7:0] IDX_GLOBAL_IE   = 8'he3;
    localparam logic [7:0] IDX_PIN_STATUS  = 8'he4;

    // Control field positions
    localparam int CTL_EN_BIT  = 7;
    localparam int CTL_POL_BIT = 6;
    localparam int CTL_CK_LSB  = 3;
    localparam int CTL_IE_BIT  = 2;
    localparam int CTL_IF_BIT  = 1;
    localparam int CTL_SS_BIT  = 0;

    // Status/enable/clear bit positions
    localparam int EVT_OVF_BIT = 0;
    localparam int EVT_ILW_BIT = 1;

    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [11:0] RST_VAL12 = 12'h000;
    localparam logic [6:0]  RST_DIV   = 7'h00;

    typedef struct packed {
        logic       unit_enable;
        logic       output_polarity_select;
        logic [2:0] clock_prescale_select;
        logic       period_irq_enable;
        logic       period_overflow_flag;
        logic       pin_output_select;
    } pwmg_ctl_s;

    typedef struct packed {
        logic [11:0] period_value;
        logic [11:0] duty_value;
    } pwmg_cfg_s;
endpackage : pwmg_pkg

/* pwmg_prescaler.sv */
module pwmg_prescaler
    import pwmg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            tick
);
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic       tick_next;
    logic [6:0] mask;

    always_comb begin
        mask      = 7'((8'h01 << sel) - 8'h01);
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (!run) begin
            cnt_next = RST_DIV;
        end else if ((cnt_reg & mask) == mask) begin
            cnt_next  = RST_DIV;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 7'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= RST_DIV;
            tick    <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick    <= tick_next;
        end
    end
endmodule : pwmg_prescaler

/* pwmg_byte_pair.sv */
module pwmg_byte_pair
    import pwmg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wr_low,
    input  wire logic        wr_high,
    input  wire logic [7:0]  wdata,
    output logic [7:0]       low_shadow,
    output logic [11:0]      value
);
    // Low byte waits in a shadow until the high byte commits both halves
    logic [7:0]  low_reg;
    logic [7:0]  low_next;
    logic [11:0] val_reg;
    logic [11:0] val_next;

    always_comb begin
        low_next = low_reg;
        val_next = val_reg;
        if (wr_low) begin
            low_next = wdata;
        end
        if (wr_high) begin
            val_next = {wdata[3:0], low_reg};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            low_reg <= RST_BYTE;
            val_reg <= RST_VAL12;
        end else begin
            low_reg <= low_next;
            val_reg <= val_next;
        end
    end

    assign low_shadow = low_reg;
    assign value      = val_reg;
endmodule : pwmg_byte_pair

/* pwmg_top.sv */
// Summary of operation
// - Control bit 7 runs the period counter; clearing it stops the modulator.
// - Polarity bit 6 zero: high during duty, low otherwise; one inverts.
// - Prescale codes 000..111 divide the system clock by 1 to 128.
// - Counter overflow sets the overflow flag in control bit 1; software clears.
// - Interrupt when overflow flag, local enable bit 2 and global enable all set, or when a status bit and its interrupt-enable bit are both set.
// - Enabled with pin-output bit 0 clear: counter runs, pin stays I/O.
// - Timer-only mode still raises the interrupt when local enable bit 2 and the global enable are set.
// - Pin output on, unit off: pin holds the inactive level.
// - Counter wraps to zero at the period value; period = value times tick.
// - Period zero holds output at the inactive level.
// - New period and duty load only at the start of the next period.
// - A low-byte write takes effect only with the following high-byte write.
// - Duty at or above period gives constant active; duty zero constant inactive.
// - Duty value sets active time per period in prescaled ticks.
// - Option strap picks which of two port pins carries the waveform.
module pwmg_top
    import pwmg_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [9:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             WB_ERR_O,
    input  wire logic        OUTPUT_PIN_CHOICE_OPTION,
    output logic             PIN_A_OUT,
    output logic             PIN_A_SEL,
    output logic             PIN_B_OUT,
    output logic             PIN_B_SEL,
    output logic             IRQ
);
    import pwmg_pkg::*;

    // Bus decode
    logic       req;
    logic [7:0] idx;
    logic       wr;
    logic       lane0;
    logic [7:0] wbyte;
    logic       mapped;

    assign req   = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
    assign idx   = WB_ADR_I[9:2];
    assign lane0 = WB_SEL_I[0];
    assign wr    = req && WB_WE_I && lane0 && WB_ADR_I[1:0] == 2'b00;
    assign wbyte = WB_DAT_I[7:0];

    always_comb begin
        case (idx)
            IDX_DUTY_LOW, IDX_DUTY_HIGH, IDX_CONTROL, IDX_PERIOD_LOW,
            IDX_PERIOD_HIGH, IDX_IRQ_STATUS, IDX_IRQ_CLEAR, IDX_IRQ_ENABLE,
            IDX_GLOBAL_IE, IDX_PIN_STATUS: mapped = (WB_ADR_I[1:0] == 2'b00);
            default: mapped = 1'b0;
        endcase
    end

    // Control register state
    pwmg_ctl_s ctl_reg;
    pwmg_ctl_s ctl_next;
    logic      gie_reg;
    logic      gie_next;
    logic [1:0] ien_reg;
    logic [1:0] ien_next;
    logic [1:0] sts_reg;
    logic [1:0] sts_next;

    // Period and duty pairs: low byte shadow plus 12-bit reload value
    logic [7:0]  per_low;
    logic [7:0]  duty_low;
    logic [11:0] per_reload;
    logic [11:0] duty_reload;

    pwmg_byte_pair u_period (
        .clk        (MCLK),
        .rst_n      (RST_N),
        .wr_low     (wr && idx == IDX_PERIOD_LOW),
        .wr_high    (wr && idx == IDX_PERIOD_HIGH),
        .wdata      (wbyte),
        .low_shadow (per_low),
        .value      (per_reload)
    );

    pwmg_byte_pair u_duty (
        .clk        (MCLK),
        .rst_n      (RST_N),
        .wr_low     (wr && idx == IDX_DUTY_LOW),
        .wr_high    (wr && idx == IDX_DUTY_HIGH),
        .wdata      (wbyte),
        .low_shadow (duty_low),
        .value      (duty_reload)
    );

    // Prescaler
    logic tick;

    pwmg_prescaler u_presc (
        .clk   (MCLK),
        .rst_n (RST_N),
        .run   (ctl_reg.unit_enable),
        .sel   (ctl_reg.clock_prescale_select),
        .tick  (tick)
    );

    // Counter and active copies
    pwmg_cfg_s   act_reg;
    pwmg_cfg_s   act_next;
    logic [11:0] cnt_reg;
    logic [11:0] cnt_next;
    logic        ovf;

    always_comb begin
        act_next = act_reg;
        cnt_next = cnt_reg;
        ovf      = 1'b0;
        if (!ctl_reg.unit_enable) begin
            cnt_next = RST_VAL12;
            act_next = '{period_value: per_reload, duty_value: duty_reload};
        end else if (tick) begin
            if (act_reg.period_value == RST_VAL12 ||
                cnt_reg + 12'h001 >= act_reg.period_value) begin
                cnt_next = RST_VAL12;
                ovf      = 1'b1;
                act_next = '{period_value: per_reload, duty_value: duty_reload};
            end else begin
                cnt_next = cnt_reg + 12'h001;
            end
        end
    end

    // Waveform: active level is high when polarity bit is zero
    logic active;
    logic wave;

    always_comb begin
        if (!ctl_reg.unit_enable || act_reg.period_value == RST_VAL12) begin
            active = 1'b0;
        end else if (act_reg.duty_value == RST_VAL12) begin
            active = 1'b0;
        end else if (act_reg.duty_value >= act_reg.period_value) begin
            active = 1'b1;
        end else begin
            active = cnt_reg < act_reg.duty_value;
        end
        wave = active ^ ctl_reg.output_polarity_select;
    end

    // Register writes; hardware set of the flag wins over a software clear
    always_comb begin
        ctl_next = ctl_reg;
        gie_next = gie_reg;
        ien_next = ien_reg;
        sts_next = sts_reg;
        if (wr && idx == IDX_CONTROL) begin
            ctl_next = pwmg_ctl_s'(wbyte);
        end
        if (wr && idx == IDX_GLOBAL_IE) begin
            gie_next = wbyte[0];
        end
        if (wr && idx == IDX_IRQ_ENABLE) begin
            ien_next = wbyte[1:0];
        end
        if (wr && idx == IDX_IRQ_CLEAR) begin
            sts_next = sts_reg & ~wbyte[1:0];
        end
        if (ovf) begin
            ctl_next.period_overflow_flag = 1'b1;
            sts_next[EVT_OVF_BIT]         = 1'b1;
        end
    end

    // Interrupt: local and global gating for the period flag, plus status bits masked by the interrupt-enable register
    logic irq_next;
    logic pin_a_sel_next;
    logic pin_b_sel_next;
    logic pin_sel;

    always_comb begin
        irq_next = (ctl_reg.period_overflow_flag && ctl_reg.period_irq_enable && gie_reg)
                 || |(sts_reg & ien_reg);
        // Pin carries the waveform only when pin-output bit set
        pin_sel        = ctl_reg.pin_output_select;
        pin_a_sel_next = pin_sel && !OUTPUT_PIN_CHOICE_OPTION;
        pin_b_sel_next = pin_sel && OUTPUT_PIN_CHOICE_OPTION;
    end

    // Read mux
    logic [7:0] rbyte;

    always_comb begin
        case (idx)
            IDX_DUTY_LOW:    rbyte = duty_low;
            IDX_DUTY_HIGH:   rbyte = {4'h0, duty_reload[11:8]};
            IDX_CONTROL:     rbyte = ctl_reg;
            IDX_PERIOD_LOW:  rbyte = per_low;
            IDX_PERIOD_HIGH: rbyte = {4'h0, per_reload[11:8]};
            IDX_IRQ_STATUS:  rbyte = {6'h00, sts_reg};
            IDX_IRQ_ENABLE:  rbyte = {6'h00, ien_reg};
            IDX_GLOBAL_IE:   rbyte = {7'h00, gie_reg};
            IDX_PIN_STATUS:  rbyte = {6'h00, ctl_reg.unit_enable, wave};
            default:         rbyte = RST_BYTE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ctl_reg   <= pwmg_ctl_s'(RST_BYTE);
            gie_reg   <= 1'b0;
            ien_reg   <= 2'b00;
            sts_reg   <= 2'b00;
            act_reg   <= '0;
            cnt_reg   <= RST_VAL12;
            WB_ACK_O  <= 1'b0;
            WB_ERR_O  <= 1'b0;
            WB_DAT_O  <= 32'h0000_0000;
            PIN_A_OUT <= 1'b0;
            PIN_A_SEL <= 1'b0;
            PIN_B_OUT <= 1'b0;
            PIN_B_SEL <= 1'b0;
            IRQ       <= 1'b0;
        end else begin
            ctl_reg   <= ctl_next;
            gie_reg   <= gie_next;
            ien_reg   <= ien_next;
            sts_reg   <= sts_next;
            act_reg   <= act_next;
            cnt_reg   <= cnt_next;
            WB_ACK_O  <= req && mapped;
            WB_ERR_O  <= req && !mapped;
            WB_DAT_O  <= (req && !WB_WE_I) ? {24'h00_0000, rbyte} : 32'h0000_0000;
            PIN_A_OUT <= wave;
            PIN_A_SEL <= pin_a_sel_next;
            PIN_B_OUT <= wave;
            PIN_B_SEL <= pin_b_sel_next;
            IRQ       <= irq_next;
        end
    end
endmodule : pwmg_top

/* pwmg_top_sva.sv */
module pwmg_chk (
    input wire logic       MCLK,
    input wire logic       RST_N,
    input wire logic       WB_CYC_I,
    input wire logic       WB_STB_I,
    input wire logic       WB_ACK_O,
    input wire logic       WB_ERR_O,
    input wire logic       OUTPUT_PIN_CHOICE_OPTION,
    input wire logic       PIN_A_OUT,
    input wire logic       PIN_A_SEL,
    input wire logic       PIN_B_OUT,
    input wire logic       PIN_B_SEL,
    input wire logic       IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held too long");
    a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    a_req_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O
        |=> WB_ACK_O || WB_ERR_O) else $error("request not answered");
    a_ack_err_excl: assert property (!(WB_ACK_O && WB_ERR_O))
        else $error("ack and err together");
    a_quiet_reset: assert property (disable iff (1'b0) !RST_N |=> !IRQ
        && !PIN_A_SEL && !PIN_B_SEL && !PIN_A_OUT) else $error("outputs live in reset");
    a_one_pin: assert property (!(PIN_A_SEL && PIN_B_SEL))
        else $error("both pins selected");
    a_pin_choice: assert property (PIN_A_SEL || PIN_B_SEL
        |-> PIN_B_SEL == $past(OUTPUT_PIN_CHOICE_OPTION)) else $error("wrong pin");
    a_same_wave: assert property (PIN_A_OUT == PIN_B_OUT)
        else $error("pins disagree");
endmodule : pwmg_chk
bind pwmg_top pwmg_chk u_pwmg_chk (.MCLK(MCLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
    .OUTPUT_PIN_CHOICE_OPTION(OUTPUT_PIN_CHOICE_OPTION), .PIN_A_OUT(PIN_A_OUT),
    .PIN_A_SEL(PIN_A_SEL), .PIN_B_OUT(PIN_B_OUT), .PIN_B_SEL(PIN_B_SEL), .IRQ(IRQ));

/* pwmg_load.sv */
module pwmg_load (
    input wire logic clk,
    input wire logic clr,
    input wire logic lvl,
    input wire logic drv,
    output int       hi
);
    timeunit 1ns;
    timeprecision 1ps;
    // Counts only cycles where the pin is really driven, so an I/O pin counts as idle
    always @(posedge clk) begin
        if (clr)
            hi <= 0;
        else if (drv && lvl)
            hi <= hi + 1;
    end
endmodule : pwmg_load

/* pwm_12bit_generator_tb.sv */
module pwm_12bit_generator_tb import pwmg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        MCLK = 0, RST_N = 0, cyc = 0, stb = 0, we = 0, opt = 0, clr = 0;
    logic [9:0]  adr = '0;
    logic [31:0] dati = '0, dato;
    logic        ack, err, pa, pas, pb, pbs, irq, e_r;
    logic [7:0]  q;
    logic [3:0]  sel = 4'hf;
    int          fails = 0, compares = 0, hi, n = 0;
    initial forever #5 MCLK = ~MCLK;
    pwmg_top u_pwmg_top (.MCLK(MCLK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dati), .WB_DAT_O(dato),
        .WB_ACK_O(ack), .WB_ERR_O(err), .OUTPUT_PIN_CHOICE_OPTION(opt), .PIN_A_OUT(pa),
        .PIN_A_SEL(pas), .PIN_B_OUT(pb), .PIN_B_SEL(pbs), .IRQ(irq));
    pwmg_load u_pwmg_load (.clk(MCLK), .clr(clr), .lvl(opt ? pb : pa),
        .drv(opt ? pbs : pas), .hi(hi));
    task automatic tally_and_finish;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    always @(posedge MCLK) begin
        n++;
        if (n == 60000) begin
            fails++;
            tally_and_finish;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge MCLK);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {i, 2'b00};
        dati <= {24'h0, d};
        do @(posedge MCLK); while (ack !== 1'b1 && err !== 1'b1);
        q = dato[7:0];
        e_r = err;
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask : wb
    task automatic rst;
        @(posedge MCLK);
        RST_N <= 0;
        repeat (3) @(posedge MCLK);
        RST_N <= 1;
    endtask : rst
    task automatic pace;
        repeat (2) @(posedge MCLK);
        #1;
    endtask : pace
    // Expected driven-high cycles over a window of whole periods
    function automatic int model(logic en, logic pol, logic ss, int p, int d, int w);
        int a;
        a = (!en || p == 0 || d == 0) ? 0 : (d >= p) ? w : w / p * d;
        return !ss ? 0 : pol ? w - a : a;
    endfunction : model
    task automatic meas(input int e, input int w);
        repeat (w + 16) @(posedge MCLK);
        clr <= 1;
        @(posedge MCLK);
        clr <= 0;
        repeat (w) @(posedge MCLK);
        #1 chk(hi, e);
    endtask : meas
    task automatic run(logic en, logic pol, logic ss, logic [2:0] ck, int p, int d);
        int w;
        w = (p == 0 ? 64 : 3 * p) << ck;
        wb(1, IDX_CONTROL, 8'h00);
        opt <= 1'($urandom_range(1));
        wb(1, IDX_DUTY_LOW, 8'(d));
        wb(1, IDX_DUTY_HIGH, 8'(d >> 8));
        wb(1, IDX_PERIOD_LOW, 8'(p));
        wb(1, IDX_PERIOD_HIGH, 8'(p >> 8));
        wb(1, IDX_CONTROL, {en, pol, ck, 2'b00, ss});
        meas(model(en, pol, ss, p, d, w), w);
    endtask : run
    initial begin
        void'($urandom(32'h3ad0));
        rst;
        wb(0, IDX_DUTY_LOW, 0); chk(q, 0);
        wb(0, IDX_DUTY_HIGH, 0); chk(q, 0);
        wb(0, IDX_CONTROL, 0); chk(q, 0);
        wb(0, IDX_PERIOD_LOW, 0); chk(q, 0);
        wb(0, IDX_PERIOD_HIGH, 0); chk(q, 0);
        wb(0, 8'h10, 0); chk(e_r, 1);
        $display("reset test done");
        for (int k = 0; k < 8; k++)
            run(1, 1'($urandom_range(1)), 1, 3'(k), $urandom_range(9, 2), $urandom_range(10));
        run(1, 0, 1, 0, 0, 3);
        run(1, 1, 1, 0, 0, 3);
        run(0, 0, 1, 2, 5, 2);
        run(0, 1, 1, 2, 5, 2);
        run(1, 0, 0, 1, 5, 2);
        run(1, 1, 1, 0, 6, 6);
        run(1, 1, 1, 0, 6, 0);
        run(1, 0, 1, 1, 6, 3);
        wb(1, IDX_PERIOD_LOW, 8'h02);
        meas(model(1, 0, 1, 6, 3, 36), 36);
        wb(1, IDX_PERIOD_HIGH, 8'h00);
        meas(model(1, 0, 1, 2, 3, 12), 12);
        $display("waveform test done");
        wb(1, IDX_CONTROL, 8'h84);
        pace;
        wb(0, IDX_CONTROL, 0); chk(q, 8'h86);
        chk(irq, 0);
        // A write without byte lane 0 is acknowledged but must leave the register alone
        sel <= 4'he;
        wb(1, IDX_GLOBAL_IE, 1);
        sel <= 4'hf;
        wb(0, IDX_GLOBAL_IE, 0);
        chk(q, 0);
        wb(1, IDX_GLOBAL_IE, 1); pace; chk(irq, 1);
        // Two clears: an overflow in the clearing cycle wins over the first one
        wb(1, IDX_CONTROL, 0); pace; chk(irq, 0);
        wb(1, IDX_CONTROL, 0); wb(0, IDX_CONTROL, 0); chk(q, 0);
        wb(0, IDX_IRQ_STATUS, 0); chk(q[0], 1);
        wb(1, IDX_IRQ_ENABLE, 1); pace; chk(irq, 1);
        wb(1, IDX_IRQ_CLEAR, 1); pace; chk(irq, 0);
        wb(0, IDX_IRQ_STATUS, 0); chk(q[0], 0);
        wb(1, IDX_IRQ_ENABLE, 0);
        $display("interrupt test done");
        wb(1, IDX_CONTROL, 8'hc1);
        pace;
        rst;
        wb(0, IDX_CONTROL, 0); chk(q, 0);
        chk(pas | pbs, 0);
        $display("second reset test done");
        tally_and_finish;
    end
endmodule : pwm_12bit_generator_tb
